// *** qspi_xfer_top.sv ***
// Register-driven master transfer engine for one, two or four data lines.
// Assumes an Avalon-MM master and an external slave sampled in SPI mode 0.
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
module qspi_xfer_top #(
  parameter int DATA_W   = qspi_xfer_pkg::DATA_W_DEF,
  parameter int HALF_DIV = qspi_xfer_pkg::HALF_DIV_DEF
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Events
  output logic             irq,
  output logic             dma_tx_req,
  output logic             dma_rx_req,
  // Serial pins
  output logic             serial_clock_out,
  output logic             slave_select_n,
  output logic      [3:0]  serial_data_lines_out,
  output logic      [3:0]  serial_data_lines_oe,
  input  wire logic [3:0]  serial_data_lines_in
);
  typedef struct packed {
    qspi_xfer_pkg::eng_state_t st;
    logic                      dir;
    logic                      mss;
    logic [1:0]                lmode;
    logic [3:0]                bcc;
    logic [3:0]                flags;
    logic [3:0]                irq_en;
    logic                      dma_tx_en;
    logic                      dma_rx_en;
    logic [DATA_W-1:0]         txd;
    logic [DATA_W-1:0]         rxd;
    logic [DATA_W-1:0]         tx_sh;
    logic [DATA_W-1:0]         rx_sh;
    logic [4:0]                clk_left;
    logic [4:0]                rises;
    logic                      sclk;
    logic                      rd_valid;
    logic [31:0]               rdata;
    logic                      dma_tx;
    logic                      dma_rx;
  } eng_t;

  eng_t s_ff;
  eng_t nxt_s;

  logic              tick;
  logic [3:0]        din;
  logic [31:0]       wmask;
  logic              wr_acc;
  logic              rd_acc;
  logic [4:0]        clocks;
  logic [2:0]        lanes;
  logic [6:0]        nbits;
  logic [6:0]        pad;
  logic              rise_ev;
  logic              fall_ev;
  logic              word_done;
  logic              capture;
  logic              te_set;
  logic              tx_wr;
  logic [DATA_W-1:0] txd_merged;

  qspi_in_sync #(
    .W (4)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .din      (serial_data_lines_in),
    .dout     (din)
  );

  qspi_half_tick #(
    .DIV (HALF_DIV)
  ) u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .run      (s_ff.st == qspi_xfer_pkg::ST_SHIFT),
    .tick     (tick)
  );

  // Bus handshake: writes take effect at once, reads answer one cycle later
  assign avs_waitrequest = avs_read && !s_ff.rd_valid;
  assign wr_acc          = avs_write;
  assign rd_acc          = avs_read && s_ff.rd_valid;
  assign avs_readdata    = s_ff.rdata;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{avs_byteenable[i]}};
    end
  end

  // Word geometry
  always_comb begin
    case (s_ff.lmode)
      qspi_xfer_pkg::LM_DUAL: lanes = qspi_xfer_pkg::LANES_2;
      qspi_xfer_pkg::LM_QUAD: lanes = qspi_xfer_pkg::LANES_4;
      default:                lanes = qspi_xfer_pkg::LANES_1;
    endcase
    clocks = {1'b0, s_ff.bcc} + 5'h01;
    nbits  = 7'(clocks) * 7'(lanes);
    pad    = (nbits >= 7'(DATA_W)) ? 7'h00 : 7'(DATA_W) - nbits;
  end

  assign rise_ev   = (s_ff.st == qspi_xfer_pkg::ST_SHIFT) && tick && !s_ff.sclk;
  assign fall_ev   = (s_ff.st == qspi_xfer_pkg::ST_SHIFT) && tick && s_ff.sclk;
  assign word_done = fall_ev && (s_ff.clk_left == 5'h01);
  assign capture   = (s_ff.lmode == qspi_xfer_pkg::LM_SINGLE) || s_ff.dir;
  assign tx_wr     = wr_acc && (avs_address == qspi_xfer_pkg::OFS_TXD);
  assign txd_merged = DATA_W'((32'(s_ff.txd) & ~wmask) | (avs_writedata & wmask));

  always_comb begin
    nxt_s          = s_ff;
    nxt_s.dma_tx   = 1'b0;
    nxt_s.dma_rx   = 1'b0;
    nxt_s.rd_valid = avs_read && !s_ff.rd_valid;
    te_set         = 1'b0;

    // Read data captured in the waiting cycle
    if (avs_read && !s_ff.rd_valid) begin
      case (avs_address)
        qspi_xfer_pkg::OFS_CTRL: begin
          nxt_s.rdata = '0;
          nxt_s.rdata[qspi_xfer_pkg::CTRL_DIR_BIT] = s_ff.dir;
          nxt_s.rdata[qspi_xfer_pkg::CTRL_MSS_BIT] = s_ff.mss;
        end
        qspi_xfer_pkg::OFS_MODE: begin
          nxt_s.rdata = '0;
          nxt_s.rdata[qspi_xfer_pkg::MODE_LM_LSB +: 2]  = s_ff.lmode;
          nxt_s.rdata[qspi_xfer_pkg::MODE_BCC_LSB +: 4] = s_ff.bcc;
        end
        qspi_xfer_pkg::OFS_TXD:      nxt_s.rdata = 32'(s_ff.txd);
        qspi_xfer_pkg::OFS_RXD:      nxt_s.rdata = 32'(s_ff.rxd);
        qspi_xfer_pkg::OFS_IRQ_FLAG: nxt_s.rdata = 32'(s_ff.flags);
        qspi_xfer_pkg::OFS_IRQ_EN:   nxt_s.rdata = 32'(s_ff.irq_en);
        qspi_xfer_pkg::OFS_DMA_EN: begin
          nxt_s.rdata = '0;
          nxt_s.rdata[qspi_xfer_pkg::DMA_TX_BIT] = s_ff.dma_tx_en;
          nxt_s.rdata[qspi_xfer_pkg::DMA_RX_BIT] = s_ff.dma_rx_en;
        end
        default: nxt_s.rdata = '0;
      endcase
    end

    // Reading receive data clears receive-full
    if (rd_acc && (avs_address == qspi_xfer_pkg::OFS_RXD)) begin
      nxt_s.flags[qspi_xfer_pkg::FLG_RX_FULL] = 1'b0;
    end

    // Register writes
    if (wr_acc) begin
      case (avs_address)
        qspi_xfer_pkg::OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            nxt_s.dir = avs_writedata[qspi_xfer_pkg::CTRL_DIR_BIT];
            nxt_s.mss = avs_writedata[qspi_xfer_pkg::CTRL_MSS_BIT];
          end
        end
        qspi_xfer_pkg::OFS_MODE: begin
          if (avs_byteenable[0]) begin
            nxt_s.lmode = avs_writedata[qspi_xfer_pkg::MODE_LM_LSB +: 2];
            nxt_s.bcc   = avs_writedata[qspi_xfer_pkg::MODE_BCC_LSB +: 4];
          end
        end
        qspi_xfer_pkg::OFS_IRQ_FLAG: begin
          // Transmit-empty is status only and ignores the clear
          for (int i = qspi_xfer_pkg::FLG_TX_END; i < qspi_xfer_pkg::FLG_COUNT; i++) begin
            if (avs_writedata[i] && avs_byteenable[0]) begin
              nxt_s.flags[i] = 1'b0;
            end
          end
        end
        qspi_xfer_pkg::OFS_IRQ_EN: begin
          if (avs_byteenable[0]) begin
            nxt_s.irq_en = avs_writedata[3:0];
          end
        end
        qspi_xfer_pkg::OFS_DMA_EN: begin
          if (avs_byteenable[0]) begin
            nxt_s.dma_tx_en = avs_writedata[qspi_xfer_pkg::DMA_TX_BIT];
            nxt_s.dma_rx_en = avs_writedata[qspi_xfer_pkg::DMA_RX_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    // Serial engine
    case (s_ff.st)
      qspi_xfer_pkg::ST_IDLE: begin
        nxt_s.sclk = 1'b0;
        if (!s_ff.flags[qspi_xfer_pkg::FLG_TX_EMPTY]) begin
          nxt_s.st       = qspi_xfer_pkg::ST_SHIFT;
          nxt_s.tx_sh    = s_ff.txd << pad;
          nxt_s.rx_sh    = '0;
          nxt_s.clk_left = clocks;
          nxt_s.rises    = '0;
          te_set         = 1'b1;
        end
      end
      qspi_xfer_pkg::ST_SHIFT: begin
        if (rise_ev) begin
          nxt_s.sclk  = 1'b1;
          nxt_s.rises = s_ff.rises + 5'h01;
          case (s_ff.lmode)
            qspi_xfer_pkg::LM_DUAL: nxt_s.rx_sh = {s_ff.rx_sh[DATA_W-3:0], din[1:0]};
            qspi_xfer_pkg::LM_QUAD: nxt_s.rx_sh = {s_ff.rx_sh[DATA_W-5:0], din[3:0]};
            default:                nxt_s.rx_sh = {s_ff.rx_sh[DATA_W-2:0], din[1]};
          endcase
        end
        if (fall_ev) begin
          nxt_s.sclk     = 1'b0;
          nxt_s.tx_sh    = s_ff.tx_sh << lanes;
          nxt_s.clk_left = s_ff.clk_left - 5'h01;
        end
        if (word_done) begin
          if (capture) begin
            nxt_s.rxd = s_ff.rx_sh;
            nxt_s.flags[qspi_xfer_pkg::FLG_RX_FULL] = 1'b1;
            nxt_s.dma_rx = s_ff.dma_rx_en;
            if (s_ff.flags[qspi_xfer_pkg::FLG_RX_FULL]) begin
              nxt_s.flags[qspi_xfer_pkg::FLG_OVERRUN] = 1'b1;
            end
          end
          if (!s_ff.flags[qspi_xfer_pkg::FLG_TX_EMPTY]) begin
            // Pending word continues without a clock gap
            nxt_s.tx_sh    = s_ff.txd << pad;
            nxt_s.rx_sh    = '0;
            nxt_s.clk_left = clocks;
            nxt_s.rises    = '0;
            te_set         = 1'b1;
          end else begin
            nxt_s.st = qspi_xfer_pkg::ST_IDLE;
            nxt_s.flags[qspi_xfer_pkg::FLG_TX_END] = 1'b1;
          end
        end
      end
      default: nxt_s.st = qspi_xfer_pkg::ST_IDLE;
    endcase

    if (te_set) begin
      nxt_s.flags[qspi_xfer_pkg::FLG_TX_EMPTY] = 1'b1;
    end
    // New data written in the load cycle keeps the buffer occupied
    if (tx_wr) begin
      nxt_s.txd = txd_merged;
      nxt_s.flags[qspi_xfer_pkg::FLG_TX_EMPTY] = 1'b0;
    end
    nxt_s.dma_tx = te_set && !tx_wr && s_ff.dma_tx_en;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff       <= '0;
      s_ff.st    <= qspi_xfer_pkg::ST_IDLE;
      s_ff.bcc   <= qspi_xfer_pkg::RST_BCC;
      s_ff.flags <= {3'h0, qspi_xfer_pkg::RST_TX_EMPTY};
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  // Outputs
  assign irq              = |(s_ff.flags & s_ff.irq_en);
  assign dma_tx_req       = s_ff.dma_tx;
  assign dma_rx_req       = s_ff.dma_rx;
  assign serial_clock_out = s_ff.sclk;
  assign slave_select_n   = !s_ff.mss;

  always_comb begin
    serial_data_lines_out = '0;
    serial_data_lines_oe  = '0;
    if (s_ff.st == qspi_xfer_pkg::ST_SHIFT) begin
      case (s_ff.lmode)
        qspi_xfer_pkg::LM_DUAL: begin
          serial_data_lines_out[1:0] = s_ff.tx_sh[DATA_W-1:DATA_W-2];
          serial_data_lines_oe[1:0]  = {2{!s_ff.dir}};
        end
        qspi_xfer_pkg::LM_QUAD: begin
          serial_data_lines_out = s_ff.tx_sh[DATA_W-1:DATA_W-4];
          serial_data_lines_oe  = {4{!s_ff.dir}};
        end
        default: begin
          serial_data_lines_out[0] = s_ff.tx_sh[DATA_W-1];
          serial_data_lines_oe[0]  = 1'b1;
        end
      endcase
    end
  end

  // Checks
  property p_load;
    @(posedge core_clk) disable iff (!rst_n)
      (ce && s_ff.st == qspi_xfer_pkg::ST_IDLE && !s_ff.flags[qspi_xfer_pkg::FLG_TX_EMPTY] && !tx_wr) |=>
        (s_ff.flags[qspi_xfer_pkg::FLG_TX_EMPTY] && s_ff.st == qspi_xfer_pkg::ST_SHIFT);
  endproperty
  a_load: assert property (p_load) else $error("transmit word not moved to shifter");

  property p_te_irq;
    @(posedge core_clk) disable iff (!rst_n)
      (s_ff.flags[qspi_xfer_pkg::FLG_TX_EMPTY] && s_ff.irq_en[qspi_xfer_pkg::FLG_TX_EMPTY]) |-> irq;
  endproperty
  a_te_irq: assert property (p_te_irq) else $error("transmit-empty interrupt missing");

  property p_clocks;
    @(posedge core_clk) disable iff (!rst_n)
      (ce && word_done) |-> (s_ff.rises == clocks);
  endproperty
  a_clocks: assert property (p_clocks) else $error("wrong serial clock count per word");

  property p_end;
    @(posedge core_clk) disable iff (!rst_n)
      (ce && word_done && s_ff.flags[qspi_xfer_pkg::FLG_TX_EMPTY]) |=>
        (s_ff.flags[qspi_xfer_pkg::FLG_TX_END] && !s_ff.sclk && s_ff.st == qspi_xfer_pkg::ST_IDLE);
  endproperty
  a_end: assert property (p_end) else $error("clock did not stop at transmit end");

  property p_dma_tx;
    @(posedge core_clk) disable iff (!rst_n)
      ($rose(s_ff.flags[qspi_xfer_pkg::FLG_TX_EMPTY]) && $past(s_ff.dma_tx_en) && $past(ce)) |->
        dma_tx_req ##1 (!dma_tx_req || !ce);
  endproperty
  a_dma_tx: assert property (p_dma_tx) else $error("transmit DMA request not one pulse");

  property p_rx_quiet;
    @(posedge core_clk) disable iff (!rst_n)
      (lanes != qspi_xfer_pkg::LANES_1 && s_ff.dir) |-> (serial_data_lines_oe == 4'h0);
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("data driven during receive");

  property p_single;
    @(posedge core_clk) disable iff (!rst_n)
      (s_ff.st == qspi_xfer_pkg::ST_SHIFT && s_ff.lmode == qspi_xfer_pkg::LM_SINGLE) |->
        (serial_data_lines_oe == 4'h1);
  endproperty
  a_single: assert property (p_single) else $error("single mode lines wrong");

  property p_dual;
    @(posedge core_clk) disable iff (!rst_n)
      (s_ff.lmode == qspi_xfer_pkg::LM_DUAL) |-> (serial_data_lines_oe[3:2] == 2'h0);
  endproperty
  a_dual: assert property (p_dual) else $error("upper lines driven in dual mode");

  property p_rx_full;
    @(posedge core_clk) disable iff (!rst_n)
      (ce && word_done && capture) |=> (s_ff.flags[qspi_xfer_pkg::FLG_RX_FULL] && s_ff.rxd == $past(s_ff.rx_sh));
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("received word not buffered");

  property p_overrun;
    @(posedge core_clk) disable iff (!rst_n)
      (ce && word_done && capture && s_ff.flags[qspi_xfer_pkg::FLG_RX_FULL]) |=> s_ff.flags[qspi_xfer_pkg::FLG_OVERRUN];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_rd_clear;
    @(posedge core_clk) disable iff (!rst_n)
      (ce && rd_acc && avs_address == qspi_xfer_pkg::OFS_RXD && !word_done) |=>
        !s_ff.flags[qspi_xfer_pkg::FLG_RX_FULL];
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("receive-full not cleared by read");

endmodule : qspi_xfer_top

// *** qspi_xfer_pkg.sv ***
// Constants shared by the register-driven serial transfer engine.
// Assumes byte addressing on the register bus with one 32-bit word per register.
package qspi_xfer_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_MODE     = 5'h04;
  localparam logic [4:0] OFS_TXD      = 5'h08;
  localparam logic [4:0] OFS_RXD      = 5'h0C;
  localparam logic [4:0] OFS_IRQ_FLAG = 5'h10;
  localparam logic [4:0] OFS_IRQ_EN   = 5'h14;
  localparam logic [4:0] OFS_DMA_EN   = 5'h18;

  // Control fields
  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_MSS_BIT = 1;

  // Mode fields
  localparam int MODE_LM_LSB  = 0;
  localparam int MODE_BCC_LSB = 4;

  // Flag and enable bit positions, shared by flag and enable registers
  localparam int FLG_TX_EMPTY = 0;
  localparam int FLG_TX_END   = 1;
  localparam int FLG_RX_FULL  = 2;
  localparam int FLG_OVERRUN  = 3;
  localparam int FLG_COUNT    = 4;

  // DMA enable bits
  localparam int DMA_TX_BIT = 0;
  localparam int DMA_RX_BIT = 1;

  // Line modes
  localparam logic [1:0] LM_SINGLE = 2'h0;
  localparam logic [1:0] LM_DUAL   = 2'h1;
  localparam logic [1:0] LM_QUAD   = 2'h2;

  // Lanes per line mode
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;

  // Reset values
  localparam logic       RST_TX_EMPTY = 1'b1;
  localparam logic [3:0] RST_BCC      = 4'h7;

  // Defaults
  localparam int DATA_W_DEF   = 16;
  localparam int HALF_DIV_DEF = 4;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } eng_state_t;

endpackage : qspi_xfer_pkg

// *** qspi_in_sync.sv ***
// Three-stage synchroniser for serial data pins.
// Assumes inputs are asynchronous to core_clk; output moves when stages two and three agree.
`timescale 1ns/100ps
module qspi_in_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;

  sync_state_t s_ff;
  sync_state_t nxt_s;

  // Agreement passes straight through so the sampler sees it without an extra stage
  always_comb begin
    for (int i = 0; i < W; i++) begin
      dout[i] = (s_ff.s2[i] == s_ff.s3[i]) ? s_ff.s3[i] : s_ff.q[i];
    end
  end

  always_comb begin
    nxt_s    = s_ff;
    nxt_s.s1 = din;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    nxt_s.q  = dout;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

endmodule : qspi_in_sync

// *** qspi_half_tick.sv ***
// Half-period tick generator for the serial clock.
// Assumes run drops between words only when the engine goes idle.
`timescale 1ns/100ps
module qspi_half_tick #(
  parameter int DIV = qspi_xfer_pkg::HALF_DIV_DEF
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Control
  input  wire logic run,
  output logic      tick
);
  typedef struct packed {
    logic [7:0] cnt;
  } tick_state_t;

  localparam logic [7:0] LAST = 8'(DIV - 1);

  tick_state_t s_ff;
  tick_state_t nxt_s;

  assign tick = run && (s_ff.cnt == LAST);

  always_comb begin
    nxt_s = s_ff;
    if (!run || tick) begin
      nxt_s.cnt = '0;
    end else begin
      nxt_s.cnt = s_ff.cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

endmodule : qspi_half_tick

// *** qspi_slave_model.sv ***
// Behavioural serial slave: shifts a preloaded word out MSB first, captures the master's lines.
// Assumes SPI mode 0; the testbench resolves the shared data lines from both enables.
`timescale 1ns/100ps
module qspi_slave_model (
  // Serial side
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic [3:0]  sdl,
  output logic      [3:0]  drv,
  output logic      [3:0]  drv_oe,
  // Test control
  input  wire logic        preload,
  input  wire logic [15:0] pdata,
  input  wire logic [2:0]  lanes,
  input  wire logic        dir_in,
  output logic      [15:0] rx_word,
  output int               n_clk
);
  logic [15:0] sh;

  // Next bits after each falling edge
  always @(negedge sclk or posedge preload) begin
    if (preload)
      sh <= pdata;
    else
      sh <= sh << lanes;
  end

  always @(posedge sclk or posedge preload) begin
    if (preload) begin
      rx_word <= 16'h0000;
      n_clk <= 0;
    end else begin
      n_clk <= n_clk + 1;
      if (lanes == 3'h4)
        rx_word <= {rx_word[11:0], sdl};
      else if (lanes == 3'h2)
        rx_word <= {rx_word[13:0], sdl[1:0]};
      else
        rx_word <= {rx_word[14:0], sdl[0]};
    end
  end

  // Drive only while selected; wide modes only when the master listens
  always_comb begin
    drv = (lanes == 3'h4) ? sh[15:12] : (lanes == 3'h2) ? {2'b00, sh[15:14]} : {2'b00, sh[15], 1'b0};
    drv_oe = 4'h0;
    if (!sel_n)
      drv_oe = (lanes == 3'h1) ? 4'h2 : !dir_in ? 4'h0 : (lanes == 3'h2) ? 4'h3 : 4'hF;
  end
endmodule : qspi_slave_model

// *** qspi_xfer_top_tb_top.sv ***
// Self-checking bench for the register-driven serial engine.
// Assumes the slave model drives the far side; reads are checked against a queue of notes.
`timescale 1ns/100ps
module qspi_xfer_top_tb_top;
  logic        core_clk, rst_n, ce, avs_read, avs_write, junk, preload, dir_in;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, t, t2;
  logic        avs_waitrequest, irq, dma_tx_req, dma_rx_req, serial_clock_out, slave_select_n;
  logic [3:0]  sdo, sdoe, sdl, drv, drv_oe, oe_seen;
  logic [15:0] pdata, rx_word, pw;
  logic [2:0]  lanes;
  logic [31:0] exp_q[$];
  int          n_clk, n_fail, samples_checked, n_tx, n_rx, seed;

  qspi_xfer_top #(.DATA_W(16), .HALF_DIV(4)) u_qspi_xfer_top (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .dma_tx_req(dma_tx_req),
    .dma_rx_req(dma_rx_req), .serial_clock_out(serial_clock_out), .slave_select_n(slave_select_n),
    .serial_data_lines_out(sdo), .serial_data_lines_oe(sdoe), .serial_data_lines_in(sdl));

  qspi_slave_model u_qspi_slave_model (
    .sclk(serial_clock_out), .sel_n(slave_select_n), .sdl(sdl), .drv(drv), .drv_oe(drv_oe),
    .preload(preload), .pdata(pdata), .lanes(lanes), .dir_in(dir_in), .rx_word(rx_word), .n_clk(n_clk));

  // Undriven lines toggle so stale values never pass
  assign sdl = (sdoe & sdo) | (~sdoe & drv_oe & drv) | (~sdoe & ~drv_oe & {4{junk}});

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    junk <= ~junk;
    if (dma_tx_req === 1'b1) n_tx++;
    if (dma_rx_req === 1'b1) n_rx++;
    if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, exp_q.pop_front());
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks=%0d failures=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask : rd

  task automatic word(input logic [31:0] txd);
    @(posedge core_clk);
    preload <= 1'b1;
    @(posedge core_clk);
    preload <= 1'b0;
    bus(qspi_xfer_pkg::OFS_TXD, 1'b1, txd);
  endtask : word

  task automatic wait_irq();
    oe_seen = 4'h0;
    for (int k = 0; k < 2000; k++) begin
      @(posedge core_clk);
      oe_seen = oe_seen | sdoe;
      if (irq === 1'b1) break;
      if (k == 1999) n_fail++;
    end
  endtask : wait_irq

  task automatic wait_dma_rx();
    for (int k = 0; k < 2000; k++) begin
      @(posedge core_clk);
      if (dma_rx_req === 1'b1) break;
      if (k == 1999) n_fail++;
    end
  endtask : wait_dma_rx

  initial begin
    rst_n = 1'b0; ce = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 5'h00;
    avs_writedata = 32'h0000_0000; junk = 1'b0; preload = 1'b0; pdata = 16'h0000;
    lanes = 3'h1; dir_in = 1'b0; n_fail = 0; samples_checked = 0; n_tx = 0; n_rx = 0;
    seed = $urandom(32'hcbee_a916);
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(qspi_xfer_pkg::OFS_IRQ_FLAG, 32'h0000_0001);
    rd(qspi_xfer_pkg::OFS_MODE, 32'h0000_0070);
    bus(5'h1C, 1'b1, 32'hFFFF_FFFF);
    rd(5'h1C, 32'h0000_0000);
    bus(qspi_xfer_pkg::OFS_IRQ_EN, 1'b1, 32'h0000_0001);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(qspi_xfer_pkg::OFS_IRQ_EN, 1'b1, 32'h0000_0002);
    bus(qspi_xfer_pkg::OFS_DMA_EN, 1'b1, 32'h0000_0003);
    rd(qspi_xfer_pkg::OFS_DMA_EN, 32'h0000_0003);
    bus(qspi_xfer_pkg::OFS_CTRL, 1'b1, 32'h0000_0002);
    @(posedge core_clk);
    chk({31'h0, slave_select_n}, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      pw = $urandom;
      t = $urandom;
      pdata <= {pw[7:0], 8'h00};
      word(t);
      wait_irq();
      chk({16'h0, rx_word}, {24'h0, t[7:0]});
      chk(32'(n_clk), 32'h0000_0008);
      rd(qspi_xfer_pkg::OFS_IRQ_FLAG, 32'h0000_0007);
      rd(qspi_xfer_pkg::OFS_RXD, {24'h0, pw[7:0]});
      rd(qspi_xfer_pkg::OFS_IRQ_FLAG, 32'h0000_0003);
      bus(qspi_xfer_pkg::OFS_IRQ_FLAG, 1'b1, 32'h0000_0002);
      rd(qspi_xfer_pkg::OFS_IRQ_FLAG, 32'h0000_0001);
    end
    // Second word queued while the first is still clocking
    pw = $urandom;
    t = $urandom;
    t2 = $urandom;
    pdata <= pw;
    word(t);
    repeat (3) @(posedge core_clk);
    rd(qspi_xfer_pkg::OFS_IRQ_FLAG, 32'h0000_0001);
    bus(qspi_xfer_pkg::OFS_TXD, 1'b1, t2);
    wait_irq();
    chk({16'h0, rx_word}, {16'h0, t[7:0], t2[7:0]});
    chk(32'(n_clk), 32'h0000_0010);
    rd(qspi_xfer_pkg::OFS_IRQ_FLAG, 32'h0000_000F);
    rd(qspi_xfer_pkg::OFS_RXD, {24'h0, pw[7:0]});
    bus(qspi_xfer_pkg::OFS_IRQ_FLAG, 1'b1, 32'h0000_000E);
    // Request-driven receive: one kick, a queued dummy, each receive request read before refill
    pw = $urandom;
    pdata <= pw;
    word(32'h0000_0000);
    bus(qspi_xfer_pkg::OFS_TXD, 1'b1, 32'h0000_0000);
    wait_dma_rx();
    rd(qspi_xfer_pkg::OFS_RXD, {24'h0, pw[15:8]});
    wait_dma_rx();
    rd(qspi_xfer_pkg::OFS_RXD, {24'h0, pw[7:0]});
    wait_irq();
    chk(32'(n_clk), 32'h0000_0010);
    rd(qspi_xfer_pkg::OFS_IRQ_FLAG, 32'h0000_0003);
    bus(qspi_xfer_pkg::OFS_IRQ_FLAG, 1'b1, 32'h0000_0002);
    // Quad receive: clock only, all four lines in
    bus(qspi_xfer_pkg::OFS_MODE, 1'b1, 32'h0000_0032);
    bus(qspi_xfer_pkg::OFS_CTRL, 1'b1, 32'h0000_0003);
    lanes <= 3'h4;
    dir_in <= 1'b1;
    pw = $urandom;
    pdata <= pw;
    word(32'h0000_FFFF);
    wait_irq();
    chk({28'h0, oe_seen}, 32'h0000_0000);
    chk(32'(n_clk), 32'h0000_0004);
    rd(qspi_xfer_pkg::OFS_RXD, {16'h0, pw});
    bus(qspi_xfer_pkg::OFS_IRQ_FLAG, 1'b1, 32'h0000_0002);
    // Dual send: two lowest lines only
    bus(qspi_xfer_pkg::OFS_MODE, 1'b1, 32'h0000_0031);
    bus(qspi_xfer_pkg::OFS_CTRL, 1'b1, 32'h0000_0002);
    lanes <= 3'h2;
    dir_in <= 1'b0;
    t = $urandom;
    word(t);
    wait_irq();
    chk({28'h0, oe_seen}, 32'h0000_0003);
    chk({16'h0, rx_word}, {24'h0, t[7:0]});
    rd(qspi_xfer_pkg::OFS_IRQ_FLAG, 32'h0000_0003);
    bus(qspi_xfer_pkg::OFS_CTRL, 1'b1, 32'h0000_0000);
    @(posedge core_clk);
    chk({31'h0, slave_select_n}, 32'h0000_0001);
    chk(32'(n_tx), 32'h0000_0008);
    chk(32'(n_rx), 32'h0000_0007);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_sim();
  end
endmodule : qspi_xfer_top_tb_top
